// ### dv/e3rx_ctrl_chk.sv
// Checker for the receive control block, bound to its ports.
// Assumes frame checks are several cycles apart.
`timescale 1ns/10ps
`default_nettype none
module e3rx_ctrl_chk #(
   parameter LOF3_CYC = 75000,
   parameter LOF2_CYC = 50000,
   parameter LOF1_CYC = 25000
) (
   input wire core_clk_in,
   input wire srst_in,
   input wire s_axi_awvalid_in,
   input wire s_axi_awready_out,
   input wire s_axi_wvalid_in,
   input wire s_axi_wready_out,
   input wire s_axi_bvalid_out,
   input wire s_axi_arvalid_in,
   input wire s_axi_arready_out,
   input wire s_axi_rvalid_out,
   input wire overhead_pos_in,
   input wire receive_data_enable_out,
   input wire frame_check_in,
   input wire force_oof_out,
   input wire [3:0] parity_count_inc_out,
   input wire oof_in,
   input wire lof_out,
   input wire status_irq_out,
   input wire port_status_irq_enable_in,
   input wire link_valid_out,
   input wire [7:0] link_byte_out,
   input wire [7:0] oh_byte_in,
   input wire gc_strobe_in,
   input wire nr_strobe_in,
   input wire auto_remote_defect_off_in,
   input wire transmit_remote_defect_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   sequence s_rd_taken;
      s_axi_arvalid_in && s_axi_arready_out;
   endsequence
   sequence s_wr_taken;
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
   endsequence
   a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid_out) else $error("read answer late");
   a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid_out) else $error("write answer late");
   a_read_refuse: assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("read taken early");
   a_write_refuse: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write taken early");
   a_data_enable: assert property (!overhead_pos_in |=> receive_data_enable_out)
      else $error("data marked as overhead");
   a_link_byte: assert property (link_valid_out |-> $past(gc_strobe_in || nr_strobe_in) &&
      link_byte_out == $past(oh_byte_in)) else $error("link byte wrong");
   a_resync_check: assert property (force_oof_out |-> $past(frame_check_in) ##1 !force_oof_out)
      else $error("forced oof off the check");
   a_parity_count: assert property (|parity_count_inc_out |-> $past(frame_check_in) &&
      parity_count_inc_out <= 4'h8) else $error("parity count bad");
   a_lof_after_oof: assert property ($rose(lof_out) |-> $past(oof_in)) else $error("lof without oof");
   a_irq_port: assert property (status_irq_out |-> port_status_irq_enable_in)
      else $error("irq without port enable");
   a_rdi_off: assert property ($past(auto_remote_defect_off_in) |-> !transmit_remote_defect_out)
      else $error("auto rdi while off");
endmodule
bind e3rx_ctrl e3rx_ctrl_chk #(.LOF3_CYC(LOF3_CYC), .LOF2_CYC(LOF2_CYC), .LOF1_CYC(LOF1_CYC)) i_chk (.*);
`default_nettype wire

// ### dv/e3rx_ctrl_tb.sv
// Testbench for the receive control block: register tasks and directed checks.
// Assumes the line model paces frames of sixteen cycles.
`include "e3rx_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module e3rx_ctrl_tb;
   localparam logic [7:0] GC_BYTE = 8'ha5;
   localparam logic [7:0] NR_BYTE = 8'h3c;
   localparam logic [7:0] A_CTRL = {`E3RX_IDX_CTRL, 2'b00};
   localparam logic [7:0] A_OHB = {`E3RX_IDX_OHB, 2'b00};
   localparam logic [7:0] A_LIVE1 = {`E3RX_IDX_LIVE1, 2'b00};
   localparam logic [7:0] A_LAT1 = {`E3RX_IDX_LAT1, 2'b00};
   logic core_clk_in = 1'b0, srst_in = 1'b1, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
   logic s_axi_arvalid_in = 1'b0, loss_of_signal_input = 1'b0, oof_in = 1'b0, ais_in = 1'b0;
   logic unframed_all_ones_in = 1'b0, rdi_bit_in = 1'b0, fa1_byte_error_in = 1'b0, fa2_byte_error_in = 1'b0;
   logic rei_in = 1'b0, auto_remote_defect_off_in = 1'b0, port_status_irq_enable_in = 1'b0;
   logic framing_count_nonzero_in = 1'b0, parity_count_nonzero_in = 1'b0, remote_error_count_nonzero_in = 1'b0;
   logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
   logic [31:0] s_axi_wdata_in = 32'h0;
   logic [4:0] fa_bit_errors_in = 5'h00;
   logic [3:0] bip_bit_errors_in = 4'h0;
   logic [2:0] payload_type_in = 3'h0, ma_tail_in = 3'h0;
   wire logic frame_check_in, overhead_pos_in, gc_strobe_in, nr_strobe_in, s_axi_awready_out, s_axi_wready_out;
   wire logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, force_oof_out, lof_out, downstream_ais_out;
   wire logic transmit_remote_defect_out, receive_data_enable_out, link_valid_out, remote_error_count_inc_out;
   wire logic status_irq_out;
   wire logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
   wire logic [31:0] s_axi_rdata_out;
   wire logic [7:0] oh_byte_in, link_byte_out;
   wire logic [4:0] framing_count_inc_out;
   wire logic [3:0] parity_count_inc_out;
   int num_errors = 0, checked = 0, cyc = 0, k;
   logic [31:0] d, zl, zf;
   logic [1:0] r;
   e3rx_line_model #(.GC_BYTE(GC_BYTE), .NR_BYTE(NR_BYTE)) i_e3rx_line_model (.core_clk_in(core_clk_in),
      .srst_in(srst_in), .frame_check_out(frame_check_in), .overhead_pos_out(overhead_pos_in),
      .oh_byte_out(oh_byte_in), .gc_strobe_out(gc_strobe_in), .nr_strobe_out(nr_strobe_in));
   e3rx_ctrl #(.LOF3_CYC(30), .LOF2_CYC(20), .LOF1_CYC(10)) i_e3rx_ctrl (.s_axi_wstrb_in(4'h3),
      .s_axi_bready_in(1'b1), .s_axi_rready_in(1'b1), .alignment_load_in(1'b0), .alignment_in(10'h000), .*);
   initial begin
      forever #20 core_clk_in = ~core_clk_in;
   end
   task automatic report_and_stop;
      if (num_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge core_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked = checked + 1;
      if (g !== e) begin
         num_errors = num_errors + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   // Bready and rready stay high, so the answer is taken at the edge it is seen.
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= {16'h0000, v};
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      do begin
         @(posedge core_clk_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end while (!s_axi_bvalid_out);
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      do begin
         @(posedge core_clk_in);
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      end while (!s_axi_rvalid_out);
      d = s_axi_rdata_out;
      r = s_axi_rresp_out;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a);
      chk(d & m, e);
   endtask
   task automatic frame2(input logic [3:0] e);
      do @(posedge core_clk_in); while (!frame_check_in);
      @(posedge core_clk_in);
      chk({remote_error_count_inc_out, parity_count_inc_out}, {e != 4'h0, e});
   endtask
   task automatic watch(input int n);
      zl = 0;
      zf = 0;
      repeat (n) begin
         @(posedge core_clk_in);
         zl = zl + {31'h0, ~receive_data_enable_out};
         zf = zf + {31'h0, force_oof_out};
      end
   endtask
   task automatic link(input logic [7:0] e);
      k = 0;
      do begin
         @(posedge core_clk_in);
         k = k + 1;
      end while (!link_valid_out && k < 40);
      chk({link_valid_out, link_byte_out}, {1'b1, e});
   endtask
   initial begin
      step(16);
      srst_in <= 1'b0;
      step(1);
      rchk(A_CTRL, 32'hffff, 32'h0);
      rchk(A_OHB, 32'hffff, 32'h0);
      rd(8'h84);
      chk({d, r}, {32'h0, `E3RX_RESP_ERR});
      wr(A_CTRL, 16'h4c52);
      rchk(A_CTRL, 32'hffff, 32'h4c52);
      wr(A_CTRL, 16'h1000);
      step(4);
      chk(downstream_ais_out, 1);
      wr(A_CTRL, 16'h0000);
      step(4);
      chk(downstream_ais_out, 0);
      for (int c = 0; c < 3; c++) begin
         {ais_in, oof_in, loss_of_signal_input} <= 3'b001 << c;
         wr(A_CTRL, 16'h0000);
         step(8);
         chk({downstream_ais_out, transmit_remote_defect_out}, 2'b11);
         rchk(A_LIVE1, 32'h1 << c, 32'h1 << c);
         wr(A_CTRL, 16'h0800 | (16'h0040 >> c));
         step(8);
         chk({downstream_ais_out, transmit_remote_defect_out}, 2'b00);
      end
      {ais_in, oof_in, loss_of_signal_input} <= 3'b100;
      auto_remote_defect_off_in <= 1'b1;
      wr(A_CTRL, 16'h0000);
      step(4);
      chk(transmit_remote_defect_out, 0);
      {ais_in, auto_remote_defect_off_in} <= 2'b00;
      wr(A_CTRL, 16'h00a4);
      step(8);
      oof_in <= 1'b1;
      step(4);
      chk({lof_out, transmit_remote_defect_out}, 2'b00);
      step(12);
      chk({lof_out, transmit_remote_defect_out}, 2'b11);
      oof_in <= 1'b0;
      wr(A_CTRL, 16'h0026);
      step(8);
      oof_in <= 1'b1;
      step(3);
      chk(lof_out, 1);
      oof_in <= 1'b0;
      wr(A_CTRL, 16'h0000);
      step(20);
      link(GC_BYTE);
      wr(A_CTRL, 16'h2000);
      step(20);
      link(NR_BYTE);
      wr(A_CTRL, 16'h0008);
      step(2);
      watch(32);
      chk(zl, 0);
      wr(A_CTRL, 16'h0001);
      step(2);
      watch(40);
      chk({zl, zf}, {32'h5, 32'h1});
      wr(A_CTRL, 16'h0001);
      watch(40);
      chk(zf, 0);
      {bip_bit_errors_in, rei_in} <= {4'h3, 1'b1};
      wr(A_CTRL, 16'h4000);
      frame2(4'h3);
      frame2(4'h3);
      wr(A_CTRL, 16'h0000);
      frame2(4'h1);
      frame2(4'h1);
      wr(A_CTRL, 16'h4000);
      oof_in <= 1'b1;
      frame2(4'h0);
      wr(A_CTRL, 16'h4400);
      frame2(4'h3);
      frame2(4'h3);
      wr(A_CTRL, 16'h4000);
      oof_in <= 1'b0;
      frame2(4'h0);
      frame2(4'h0);
      frame2(4'h3);
      {fa_bit_errors_in, fa1_byte_error_in, fa2_byte_error_in} <= {5'h05, 2'b11};
      for (int m = 1; m < 4; m++) begin
         wr(A_CTRL, {6'h00, m[1:0], 8'h00});
         frame2(4'h1);
         frame2(4'h1);
         chk(framing_count_inc_out, m == 1 ? 5 : m - 1);
      end
      wr(A_CTRL, 16'h0000);
      oof_in <= 1'b1;
      zf = 0;
      repeat (6) begin
         @(posedge core_clk_in);
         zf = zf + {27'h0, framing_count_inc_out};
      end
      chk(zf, 1);
      {oof_in, payload_type_in, ma_tail_in} <= {1'b0, 3'h5, 3'h5};
      wr(A_OHB, 16'h0001);
      step(160);
      rchk(A_LIVE1, 32'h1800, 32'h0800);
      rchk({`E3RX_IDX_MAB, 2'b00}, 32'h7f, 32'h55);
      wr(A_OHB, 16'h000b);
      rchk(A_OHB, 32'hffff, 32'h000b);
      rchk(A_LIVE1, 32'h1800, 32'h0);
      {unframed_all_ones_in, rdi_bit_in, remote_error_count_nonzero_in, framing_count_nonzero_in} <= 4'hf;
      step(4);
      rchk(A_LIVE1, 32'h0108, 32'h0108);
      rchk({`E3RX_IDX_LIVE2, 2'b00}, 32'h7, 32'h5);
      wr(A_LAT1, 16'hffff);
      rchk(A_LAT1, 32'h011f, 32'h0);
      loss_of_signal_input <= 1'b1;
      step(8);
      rchk(A_LAT1, 32'h011f, 32'h1);
      wr({`E3RX_IDX_LATEN, 2'b00}, 16'h0001);
      port_status_irq_enable_in <= 1'b1;
      step(2);
      chk(status_irq_out, 1);
      port_status_irq_enable_in <= 1'b0;
      step(2);
      chk(status_irq_out, 0);
      wr(A_LAT1, 16'h0001);
      rchk(A_LAT1, 32'h1, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire

// ### dv/e3rx_line_model.sv
// Model of the incoming line side: paces frames and overhead byte strobes.
// Assumes the framer samples these on the rising edge of core_clk_in.
`timescale 1ns/10ps
`default_nettype none
module e3rx_line_model #(
   parameter logic [7:0] GC_BYTE = 8'h00,
   parameter logic [7:0] NR_BYTE = 8'h00,
   parameter int FRAME = 16
) (
   input wire logic core_clk_in,
   input wire logic srst_in,
   output logic frame_check_out,
   output logic overhead_pos_out,
   output logic [7:0] oh_byte_out,
   output logic gc_strobe_out,
   output logic nr_strobe_out
);
   logic [7:0] pos;
   always @(posedge core_clk_in) begin
      if (srst_in || pos == 8'(FRAME - 1)) begin
         pos <= 8'h00;
      end else begin
         pos <= pos + 8'h01;
      end
   end
   assign frame_check_out = !srst_in && pos == 8'(FRAME - 1);
   assign overhead_pos_out = pos < 8'h02;
   assign gc_strobe_out = !srst_in && pos == 8'h00;
   assign nr_strobe_out = !srst_in && pos == 8'h01;
   // Off the strobes the lane changes every cycle, so a stale byte cannot pass for a fresh one.
   assign oh_byte_out = gc_strobe_out ? GC_BYTE : nr_strobe_out ? NR_BYTE : pos ^ 8'h5a;
endmodule
`default_nettype wire

// ### src/e3rx_consts.vh
// Constants for the E3 G.832 receive framer control block.
// Assumes a 25 MHz core clock and word-aligned AXI4-Lite byte addresses.
`ifndef E3RX_CONSTS_VH
`define E3RX_CONSTS_VH
// Register indexes; the byte address is four times the index.
`define E3RX_IDX_CTRL 6'h20
`define E3RX_IDX_OHB 6'h22
`define E3RX_IDX_LIVE1 6'h24
`define E3RX_IDX_LIVE2 6'h26
`define E3RX_IDX_LAT1 6'h28
`define E3RX_IDX_LATEN 6'h2c
`define E3RX_IDX_MAB 6'h30
`define E3RX_RESET16 16'h0000
// Control register fields.
`define E3RX_C_PEC 14
`define E3RX_C_DLS 13
`define E3RX_C_MAN 12
`define E3RX_C_AAD 11
`define E3RX_C_ECC 10
`define E3RX_C_FEC_HI 9
`define E3RX_C_FEC_LO 8
`define E3RX_C_LOFEN 7
`define E3RX_C_LOSD 6
`define E3RX_C_OOFD 5
`define E3RX_C_AISD 4
`define E3RX_C_OMD 3
`define E3RX_C_LIP_HI 2
`define E3RX_C_LIP_LO 1
`define E3RX_C_FRS 0
`define E3RX_O_EPT_HI 3
`define E3RX_O_EPT_LO 1
`define E3RX_O_TIMING_INDICATOR_EXTRACT_OFF 0
// Framing-error count modes.
`define E3RX_FEC_OOF 2'b00
`define E3RX_FEC_BIT 2'b01
`define E3RX_FEC_WORD 2'b10
`define E3RX_FEC_BYTE 2'b11
`define E3RX_LIP_3MS 2'b00
`define E3RX_LIP_2MS 2'b01
`define E3RX_LIP_1MS 2'b10
// Timing.
`define E3RX_CLK_KHZ 25000
`define E3RX_LOF3_MS 3
`define E3RX_LOF2_MS 2
`define E3RX_LOF1_MS 1
`define E3RX_HOLD_FRAMES 2'h2
`define E3RX_PT_STABLE 3'h5
`define E3RX_TI_STABLE 2'h3
`define E3RX_RESP_OK 2'b00
`define E3RX_RESP_ERR 2'b10
`endif

// ### src/e3rx_ctrl.v
// Receive-side control and status of one G.832 E3 framer port, AXI4-Lite slave.
// Assumes the frame processor runs on core_clk_in and marks each framing-word
// check with frame_check_in; only the loss-of-signal pin is asynchronous.
// How it works
// - parity counts one block or each bit
// - data link from GC or NR byte
// - manual bit inserts downstream AIS
// - LOS, OOF, AIS insert AIS unless disabled
// - gate counting during OOF/AIS, parity and REI plus two frames
// - framing count selector picks counted event
// - LOF drives RDI when enabled
// - LOS, OOF, AIS drive RDI unless disabled
// - overhead marked unless masking disabled
// - OOF integrated 3/2/1 ms or immediate
// - rising resync bit forces OOF at check
// - expected payload type held in bits 3:1
// - timing bits extracted or integrated
// - mismatch when payload type differs
// - live bit shows unstable payload type
// - live bits for all-ones, LOF, AIS, OOF
// - LOS bit follows loss input pin
// - live bit shows received RDI
// - bits show counters non-zero
// - latched bit set on live change, none for RDI
// - latched bit on new frame alignment
// - interrupt needs bit and port enable
`include "e3rx_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module e3rx_ctrl #(
   parameter LOF3_CYC = `E3RX_LOF3_MS * `E3RX_CLK_KHZ,
   parameter LOF2_CYC = `E3RX_LOF2_MS * `E3RX_CLK_KHZ,
   parameter LOF1_CYC = `E3RX_LOF1_MS * `E3RX_CLK_KHZ
) (
   input wire core_clk_in,
   input wire srst_in,
   input wire [7:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output wire s_axi_awready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output wire s_axi_wready_out,
   output reg [1:0] s_axi_bresp_out,
   output reg s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire [7:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output wire s_axi_arready_out,
   output reg [31:0] s_axi_rdata_out,
   output reg [1:0] s_axi_rresp_out,
   output reg s_axi_rvalid_out,
   input wire s_axi_rready_in,
   input wire loss_of_signal_input,
   input wire frame_check_in,
   input wire oof_in,
   input wire ais_in,
   input wire unframed_all_ones_in,
   input wire rdi_bit_in,
   input wire [4:0] fa_bit_errors_in,
   input wire fa1_byte_error_in,
   input wire fa2_byte_error_in,
   input wire [3:0] bip_bit_errors_in,
   input wire rei_in,
   input wire [2:0] payload_type_in,
   input wire [2:0] ma_tail_in,
   input wire overhead_pos_in,
   input wire [7:0] oh_byte_in,
   input wire gc_strobe_in,
   input wire nr_strobe_in,
   input wire alignment_load_in,
   input wire [9:0] alignment_in,
   input wire framing_count_nonzero_in,
   input wire parity_count_nonzero_in,
   input wire remote_error_count_nonzero_in,
   input wire auto_remote_defect_off_in,
   input wire port_status_irq_enable_in,
   output reg force_oof_out,
   output reg lof_out,
   output reg downstream_ais_out,
   output reg transmit_remote_defect_out,
   output reg receive_data_enable_out,
   output reg [7:0] link_byte_out,
   output reg link_valid_out,
   output reg [4:0] framing_count_inc_out,
   output reg [3:0] parity_count_inc_out,
   output reg remote_error_count_inc_out,
   output wire status_irq_out
);
   reg [15:0] ctrl;
   reg [15:0] ohb;
   reg [15:0] lat1;
   reg [15:0] laten;
   reg los_meta, los;
   reg aw_got, w_got;
   reg [5:0] aw_idx;
   reg [31:0] wdata;
   reg [3:0] wstrb;
   reg frs_prev, resync_pend;
   reg [16:0] lof_cnt;
   reg [1:0] hold;
   reg cond_prev, oof_prev;
   reg [2:0] pt_cand, pt_acc;
   reg [2:0] pt_cnt;
   reg [2:0] ti_cand;
   reg [1:0] ti_cnt;
   reg [3:0] ti;
   reg [1:0] ti_slot;
   reg [9:0] align_prev;
   reg [15:0] live_prev;
   reg [15:0] rd_val;
   reg rd_hit;
   reg [15:0] next_lat;
   reg [15:0] wmask;
   reg [16:0] lof_lim;
   wire [1:0] fec_sel = ctrl[`E3RX_C_FEC_HI:`E3RX_C_FEC_LO];
   wire [1:0] lip_sel = ctrl[`E3RX_C_LIP_HI:`E3RX_C_LIP_LO];
   wire [2:0] expected_payload_type = ohb[`E3RX_O_EPT_HI:`E3RX_O_EPT_LO];
   wire cond = oof_in | ais_in;
   wire pt_unstable = (pt_cnt != `E3RX_PT_STABLE);
   wire pt_mismatch = (pt_acc != expected_payload_type);
   wire [15:0] live1;
   wire [15:0] live2;
   wire wr_go = aw_got & w_got;
   wire [15:0] lat_w1c;

   // Live conditions; LOS comes straight from the synchronised pin.
   assign live1 = {3'h0, pt_unstable, pt_mismatch, 2'h0, unframed_all_ones_in,
                   3'h0, lof_out, rdi_bit_in, ais_in, oof_in, los};
   assign live2 = {13'h0, remote_error_count_nonzero_in, parity_count_nonzero_in,
                   framing_count_nonzero_in};
   assign status_irq_out = port_status_irq_enable_in & (|(lat1 & laten));

   // The pin is not on this clock, so only the second flop is read.
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         los_meta <= 1'b0;
         los <= 1'b0;
      end else begin
         los_meta <= loss_of_signal_input;
         los <= los_meta;
      end
   end

   assign s_axi_awready_out = ~aw_got & ~s_axi_bvalid_out;
   assign s_axi_wready_out = ~w_got & ~s_axi_bvalid_out;
   assign s_axi_arready_out = ~s_axi_rvalid_out;

   always @* begin
      wmask = {{8{wstrb[1]}}, {8{wstrb[0]}}};
   end

   assign lat_w1c = (wr_go && aw_idx == `E3RX_IDX_LAT1) ? (wdata[15:0] & wmask) : 16'h0000;

   // Write path: address and data are held separately and committed together.
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_idx <= 6'h00;
         wdata <= 32'h00000000;
         wstrb <= 4'h0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `E3RX_RESP_OK;
         ctrl <= `E3RX_RESET16;
         ohb <= `E3RX_RESET16;
         laten <= `E3RX_RESET16;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_got <= 1'b1;
            aw_idx <= s_axi_awaddr_in[7:2];
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_got <= 1'b1;
            wdata <= s_axi_wdata_in;
            wstrb <= s_axi_wstrb_in;
         end
         if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
         if (wr_go) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= `E3RX_RESP_OK;
            if (aw_idx == `E3RX_IDX_CTRL) begin
               ctrl <= (ctrl & ~wmask) | (wdata[15:0] & wmask);
            end else if (aw_idx == `E3RX_IDX_OHB) begin
               ohb <= (ohb & ~wmask) | (wdata[15:0] & wmask & 16'h000f);
            end else if (aw_idx == `E3RX_IDX_LATEN) begin
               laten <= (laten & ~wmask) | (wdata[15:0] & wmask);
            end else if (aw_idx == `E3RX_IDX_LIVE1 || aw_idx == `E3RX_IDX_LIVE2 ||
                         aw_idx == `E3RX_IDX_LAT1 || aw_idx == `E3RX_IDX_MAB) begin
               s_axi_bresp_out <= `E3RX_RESP_OK;
            end else begin
               s_axi_bresp_out <= `E3RX_RESP_ERR;
            end
         end
      end
   end

   always @* begin
      rd_hit = 1'b1;
      rd_val = 16'h0000;
      if (s_axi_araddr_in[7:2] == `E3RX_IDX_CTRL) begin
         rd_val = ctrl;
      end else if (s_axi_araddr_in[7:2] == `E3RX_IDX_OHB) begin
         rd_val = ohb;
      end else if (s_axi_araddr_in[7:2] == `E3RX_IDX_LIVE1) begin
         rd_val = live1;
      end else if (s_axi_araddr_in[7:2] == `E3RX_IDX_LIVE2) begin
         rd_val = live2;
      end else if (s_axi_araddr_in[7:2] == `E3RX_IDX_LAT1) begin
         rd_val = lat1;
      end else if (s_axi_araddr_in[7:2] == `E3RX_IDX_LATEN) begin
         rd_val = laten;
      end else if (s_axi_araddr_in[7:2] == `E3RX_IDX_MAB) begin
         rd_val = {9'h000, pt_acc, ti};
      end else begin
         rd_hit = 1'b0;
      end
   end

   always @(posedge core_clk_in) begin
      if (srst_in) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h00000000;
         s_axi_rresp_out <= `E3RX_RESP_OK;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= {16'h0000, rd_val};
         s_axi_rresp_out <= rd_hit ? `E3RX_RESP_OK : `E3RX_RESP_ERR;
      end else if (s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
      end
   end

   // Only a fresh rising edge of the bit arms a resync, so a bit left set
   // does not keep the framer hunting.
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         frs_prev <= 1'b0;
         resync_pend <= 1'b0;
         force_oof_out <= 1'b0;
      end else begin
         frs_prev <= ctrl[`E3RX_C_FRS];
         force_oof_out <= 1'b0;
         if (frame_check_in && resync_pend) begin
            resync_pend <= 1'b0;
            force_oof_out <= 1'b1;
         end
         if (ctrl[`E3RX_C_FRS] && !frs_prev) begin
            resync_pend <= 1'b1;
         end
      end
   end

   always @* begin
      if (lip_sel == `E3RX_LIP_3MS) begin
         lof_lim = LOF3_CYC[16:0];
      end else if (lip_sel == `E3RX_LIP_2MS) begin
         lof_lim = LOF2_CYC[16:0];
      end else begin
         lof_lim = LOF1_CYC[16:0];
      end
   end

   // OOF integration towards LOF.
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         lof_cnt <= 17'h00000;
         lof_out <= 1'b0;
      end else if (!oof_in) begin
         lof_cnt <= 17'h00000;
         lof_out <= 1'b0;
      end else if (lip_sel == 2'b11) begin
         lof_out <= 1'b1;
      end else if (lof_cnt >= lof_lim - 17'h00001) begin
         lof_out <= 1'b1;
      end else begin
         lof_cnt <= lof_cnt + 17'h00001;
      end
   end

   // Alarm and data-path outputs, registered.
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         downstream_ais_out <= 1'b0;
         transmit_remote_defect_out <= 1'b0;
         receive_data_enable_out <= 1'b0;
         link_byte_out <= 8'h00;
         link_valid_out <= 1'b0;
      end else begin
         downstream_ais_out <= ctrl[`E3RX_C_MAN] |
            (~ctrl[`E3RX_C_AAD] & (los | oof_in | ais_in));
         transmit_remote_defect_out <= ~auto_remote_defect_off_in &
            ((lof_out & ctrl[`E3RX_C_LOFEN]) |
             (los & ~ctrl[`E3RX_C_LOSD]) | (oof_in & ~ctrl[`E3RX_C_OOFD]) |
             (ais_in & ~ctrl[`E3RX_C_AISD]));
         receive_data_enable_out <= ~(overhead_pos_in & ~ctrl[`E3RX_C_OMD]);
         link_valid_out <= ctrl[`E3RX_C_DLS] ? nr_strobe_in : gc_strobe_in;
         if (ctrl[`E3RX_C_DLS] ? nr_strobe_in : gc_strobe_in) begin
            link_byte_out <= oh_byte_in;
         end
      end
   end

   // Error counting with hold-off: the frame where OOF/AIS ends and the next
   // one still carry unreliable parity, so they are skipped.
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         hold <= 2'h0;
         cond_prev <= 1'b0;
         oof_prev <= 1'b0;
         framing_count_inc_out <= 5'h00;
         parity_count_inc_out <= 4'h0;
         remote_error_count_inc_out <= 1'b0;
      end else begin
         cond_prev <= cond;
         oof_prev <= oof_in;
         framing_count_inc_out <= 5'h00;
         parity_count_inc_out <= 4'h0;
         remote_error_count_inc_out <= 1'b0;
         if (cond_prev && !cond) begin
            hold <= `E3RX_HOLD_FRAMES;
         end else if (frame_check_in && hold != 2'h0) begin
            hold <= hold - 2'h1;
         end
         if (fec_sel == `E3RX_FEC_OOF) begin
            framing_count_inc_out <= {4'h0, oof_in & ~oof_prev};
         end else if (frame_check_in && (ctrl[`E3RX_C_ECC] || !cond)) begin
            if (fec_sel == `E3RX_FEC_BIT) begin
               framing_count_inc_out <= fa_bit_errors_in;
            end else if (fec_sel == `E3RX_FEC_WORD) begin
               framing_count_inc_out <= {4'h0, fa1_byte_error_in | fa2_byte_error_in};
            end else begin
               framing_count_inc_out <= {3'h0, fa1_byte_error_in & fa2_byte_error_in,
                                         fa1_byte_error_in ^ fa2_byte_error_in};
            end
         end
         if (frame_check_in && (ctrl[`E3RX_C_ECC] || (!cond && hold == 2'h0))) begin
            parity_count_inc_out <= ctrl[`E3RX_C_PEC] ? bip_bit_errors_in :
               {3'h0, bip_bit_errors_in != 4'h0};
            remote_error_count_inc_out <= rei_in;
         end
      end
   end

   // Payload type and timing source, sampled once per frame.
   always @(posedge core_clk_in) begin
      if (srst_in) begin
         pt_cand <= 3'h0;
         pt_acc <= 3'h0;
         pt_cnt <= 3'h0;
         ti_cand <= 3'h0;
         ti_cnt <= 2'h0;
         ti <= 4'h0;
         ti_slot <= 2'h0;
      end else if (frame_check_in) begin
         if (payload_type_in != pt_cand) begin
            pt_cand <= payload_type_in;
            pt_cnt <= 3'h0;
         end else if (pt_unstable) begin
            pt_cnt <= pt_cnt + 3'h1;
            if (pt_cnt == `E3RX_PT_STABLE - 3'h1) begin
               pt_acc <= pt_cand;
            end
         end
         if (!ohb[`E3RX_O_TIMING_INDICATOR_EXTRACT_OFF]) begin
            // MA bits 6 and 7 number the slot, bit 8 carries its value.
            ti_slot <= ma_tail_in[2:1];
            ti[ma_tail_in[2:1]] <= ma_tail_in[0];
         end else if (ma_tail_in != ti_cand) begin
            ti_cand <= ma_tail_in;
            ti_cnt <= 2'h0;
         end else if (ti_cnt != `E3RX_TI_STABLE) begin
            ti_cnt <= ti_cnt + 2'h1;
            if (ti_cnt == `E3RX_TI_STABLE - 2'h1) begin
               ti <= {1'b0, ti_cand};
            end
         end
      end
   end

   // Latched status: a set in the same cycle as a clear wins.
   always @* begin
      next_lat = (lat1 & ~lat_w1c) | ((live1 ^ live_prev) & 16'h0117);
      next_lat[12] = next_lat[12] | (pt_unstable & ~live_prev[12]);
      next_lat[11] = next_lat[11] | (pt_mismatch & ~live_prev[11]);
      next_lat[10] = next_lat[10] | (pt_acc != pt_cand && !pt_unstable);
      next_lat[13] = lat1[13] & ~lat_w1c[13];
      next_lat[5] = (lat1[5] & ~lat_w1c[5]) |
         (alignment_load_in & (alignment_in != align_prev));
   end

   always @(posedge core_clk_in) begin
      if (srst_in) begin
         lat1 <= 16'h0000;
         live_prev <= 16'h0000;
         align_prev <= 10'h000;
      end else begin
         lat1 <= next_lat;
         live_prev <= live1;
         if (alignment_load_in) begin
            align_prev <= alignment_in;
         end
      end
   end
endmodule
`default_nettype wire
